//--- core/fft_map.svh
// register offsets, field positions and reset values of the fft accelerator
`ifndef FFT_MAP_SVH
`define FFT_MAP_SVH
// register byte offsets
`define FFT_CTRL_OFS 16'h0000
`define FFT_REAL_OFS 16'h0004
`define FFT_IMAG_OFS 16'h0008
`define FFT_WIN_OFS 16'h000c
`define FFT_OUT_OFS 16'h0010
`define FFT_LOOP_OFS 16'h0014
// sram window, end exclusive
`define FFT_SRAM_LO 16'h0800
`define FFT_SRAM_HI 16'h3000
// control_status fields
`define FFT_EN_BIT 0
`define FFT_PTS_LSB 1
`define FFT_INV_BIT 4
`define FFT_WIN_BIT 8
`define FFT_DEC_LSB 9
`define FFT_IE_BIT 29
`define FFT_CF_BIT 30
`define FFT_BSY_BIT 31
// reset value of every register
`define FFT_RST_WORD 32'h0000_0000
`endif

//--- core/fft_pkg.sv
// types shared by the fft accelerator
package fft_pkg;
   // sequencer states
   typedef enum logic [3:0] {ST_IDLE, ST_LD_RE, ST_LD_IM, ST_LD_WIN, ST_LD_PUT, ST_BFLY,
      ST_ST_RE, ST_ST_IM, ST_FINISH} state_t;
endpackage

//--- core/fft_accelerator.sv
// fft accelerator: wishbone register slave, wishbone data master, sram and butterfly
//
// Chosen here: the address map and the Wishbone interface to the registers.
`include "fft_map.svh"

module fft_accelerator #(
   parameter int LOG_MAX = 10 // log2 of the largest transform
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // register and sram slave
   input wire logic s_cyc_i,
   input wire logic s_stb_i,
   input wire logic s_we_i,
   input wire logic [15:0] s_adr_i,
   input wire logic [3:0] s_sel_i,
   input wire logic [31:0] s_dat_i,
   output logic [31:0] s_dat_o,
   output logic s_ack_o,
   output logic s_err_o,
   // data master
   output logic m_cyc_o,
   output logic m_stb_o,
   output logic m_we_o,
   output logic [31:0] m_adr_o,
   output logic [3:0] m_sel_o,
   output logic [31:0] m_dat_o,
   input wire logic [31:0] m_dat_i,
   input wire logic m_ack_i,
   input wire logic m_err_i,
   // completion interrupt
   output logic irq_o
);
   localparam int AW = LOG_MAX; // sram index width
   localparam int DEPTH = 1 << LOG_MAX; // points per array
   localparam int HALF = DEPTH / 2; // twiddle entries
   localparam logic [2:0] MAXC = 3'(LOG_MAX - 5); // highest point code

   // refuse sizes below the smallest point code or too large for the sram window
   if (LOG_MAX < 5 || LOG_MAX > 10)
   begin : g_chk
      $error("LOG_MAX must lie in 5..10");
   end

   ////////////////////////////////////////////////////////////////////////////
   // float helpers

   // flush denormal to zero, nan to infinity
   function automatic logic [31:0] fclean(input logic [31:0] x);
      if (x[30:23] == 8'h00)
         return {x[31], 31'h0};
      if (x[30:23] == 8'hff)
         return {x[31], 8'hff, 23'h0};
      return x;
   endfunction

   // sign flip
   function automatic logic [31:0] fneg(input logic [31:0] x);
      return {~x[31], x[30:0]};
   endfunction

   function automatic logic [31:0] fmul(input logic [31:0] a, input logic [31:0] b);
      logic [31:0] x;
      logic [31:0] y;
      logic [47:0] p;
      logic signed [9:0] e;
      logic s;
      x = fclean(a);
      y = fclean(b);
      s = x[31] ^ y[31];
      p = {1'b1, x[22:0]} * {1'b1, y[22:0]};
      e = 10'(x[30:23]) + 10'(y[30:23]) - 10'sd127;
      if (x[30:23] == 8'hff || y[30:23] == 8'hff)
         return {s, 8'hff, 23'h0};
      if (x[30:23] == 8'h00 || y[30:23] == 8'h00)
         return {s, 31'h0};
      if (p[47])
      begin
         p = p >> 1;
         e = e + 10'sd1;
      end
      if (e >= 10'sd255)
         return {s, 8'hff, 23'h0};
      if (e <= 10'sd0)
         return {s, 31'h0};
      return {s, e[7:0], p[45:23]};
   endfunction

   function automatic logic [31:0] fadd(input logic [31:0] a, input logic [31:0] b);
      logic [31:0] x;
      logic [31:0] y;
      logic [31:0] t;
      logic [26:0] my;
      logic [26:0] r;
      logic [7:0] d;
      logic signed [9:0] e;
      x = fclean(a);
      y = fclean(b);
      // larger magnitude first
      if (y[30:0] > x[30:0])
      begin
         t = x;
         x = y;
         y = t;
      end
      if (x[30:23] == 8'hff || y[30:23] == 8'h00)
         return x;
      d = x[30:23] - y[30:23];
      my = (d > 8'd26) ? 27'h0 : ({2'b01, y[22:0], 2'b00} >> d);
      r = (x[31] == y[31]) ? {2'b01, x[22:0], 2'b00} + my : {2'b01, x[22:0], 2'b00} - my;
      if (r == 27'h0)
         return 32'h0;
      e = 10'(x[30:23]);
      if (r[26])
      begin
         r = r >> 1;
         e = e + 10'sd1;
      end
      // renormalise after cancellation
      for (int i = 0; i < 25; i++)
      begin
         if (!r[25])
         begin
            r = r << 1;
            e = e - 10'sd1;
         end
      end
      if (e >= 10'sd255)
         return {x[31], 8'hff, 23'h0};
      if (e <= 10'sd0)
         return {x[31], 31'h0};
      return {x[31], e[7:0], r[24:2]};
   endfunction

   // divide by a power of two
   function automatic logic [31:0] fscale(input logic [31:0] x, input logic [3:0] sh);
      if (x[30:23] == 8'h00 || x[30:23] == 8'hff)
         return x;
      if (x[30:23] <= {4'h0, sh})
         return {x[31], 31'h0};
      return {x[31], x[30:23] - {4'h0, sh}, x[22:0]};
   endfunction

   // reverse the low l bits of an index
   function automatic logic [AW-1:0] bitrev(input logic [AW-1:0] i, input logic [3:0] l);
      logic [AW-1:0] r;
      r = '0;
      for (int b = 0; b < AW; b++)
      begin
         if (b < l)
            r[l - 1 - b] = i[b];
      end
      return r;
   endfunction

   // real constant to single, elaboration only
   function automatic logic [31:0] to_single(input real v);
      logic [63:0] d;
      d = $realtobits(v);
      if (d[62:52] < 11'd897)
         return 32'h0;
      return {d[63], 8'(d[62:52] - 11'd896), d[51:29]};
   endfunction

   // byte lane merge
   function automatic logic [31:0] bmerge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
      logic [31:0] m;
      m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
      return (o & ~m) | (n & m);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // state

   logic enable; // compute_enable, cleared at finish
   logic inverse; // inverse_select
   logic win_en; // window multiply on
   logic ie; // completion interrupt enable
   logic flag; // completion_flag
   logic [2:0] pts_code; // point_count_select
   logic [3:0] decim; // decimation_select
   logic [31:0] real_base; // real_base_address
   logic [31:0] imag_base; // imag_base_address
   logic [31:0] win_base; // window base
   logic [31:0] out_base; // output base
   logic [15:0] loop_len; // loop_control length
   logic [15:0] loop_idx; // loop_control index
   fft_pkg::state_t state; // sequencer
   logic [AW-1:0] idx; // sample counter
   logic [3:0] stage; // butterfly pass
   logic [AW-2:0] bf; // butterfly within pass
   logic [31:0] smp_re; // fetched real
   logic [31:0] smp_im; // fetched imag
   logic [31:0] smp_w; // fetched window
   logic [31:0] mem_re [DEPTH]; // real half of sram
   logic [31:0] mem_im [DEPTH]; // imag half of sram
   logic [31:0] tw_c [HALF]; // cosine table
   logic [31:0] tw_s [HALF]; // sine table
   logic [3:0] lg; // log2 of N
   logic [AW-1:0] last; // N-1
   logic done; // finish pulse
   logic bus_st; // master state
   logic bus_done; // master cycle answered
   logic [31:0] bus_adr; // next master address
   logic [31:0] bus_dat; // next master write word
   logic [31:0] fetch_off; // input byte offset

   // clamp reserved codes to the largest size
   assign lg = 4'd5 + 4'((pts_code > MAXC) ? MAXC : pts_code);
   assign last = AW'((32'd1 << lg) - 32'd1);
   assign done = (state == fft_pkg::ST_FINISH);
   assign irq_o = flag & ie;

   for (genvar g = 0; g < HALF; g++)
   begin : g_tw
      localparam real ANG = 6.283185307179586 * g / DEPTH;
      assign tw_c[g] = to_single($cos(ANG));
      assign tw_s[g] = to_single($sin(ANG));
   end

   ////////////////////////////////////////////////////////////////////////////
   // register slave

   logic take; // new slave request
   logic reg_wr; // register write
   logic ctrl_wr; // control_status write
   logic ram_hit; // address in sram window
   logic ram_in; // address backed by storage
   logic ram_wr; // sram write from bus
   logic [11:0] ram_w; // sram word index
   logic [31:0] ram_rd; // sram read word
   logic [31:0] ctrl_word; // control_status read
   logic [31:0] rd_word; // read mux

   assign take = s_cyc_i & s_stb_i & ~s_ack_o & ~s_err_o;
   assign reg_wr = take & s_we_i & (s_sel_i == 4'hf);
   assign ctrl_wr = reg_wr && s_adr_i == `FFT_CTRL_OFS;
   assign ram_hit = s_adr_i >= `FFT_SRAM_LO && s_adr_i < `FFT_SRAM_HI;
   assign ram_w = 12'((s_adr_i - `FFT_SRAM_LO) >> 2);
   assign ram_in = ram_w < 12'(2 * DEPTH);
   // bus writes sram only while idle
   assign ram_wr = take & s_we_i & ram_hit & ram_in & ~enable;
   assign ram_rd = (ram_hit && ram_in) ? (ram_w[LOG_MAX] ? mem_im[ram_w[AW-1:0]] : mem_re[ram_w[AW-1:0]]) : 32'h0;

   // read data mux, unmapped reads zero
   always_comb
   begin
      ctrl_word = `FFT_RST_WORD;
      ctrl_word[`FFT_EN_BIT] = enable;
      ctrl_word[`FFT_PTS_LSB +: 3] = pts_code;
      ctrl_word[`FFT_INV_BIT] = inverse;
      ctrl_word[`FFT_WIN_BIT] = win_en;
      ctrl_word[`FFT_DEC_LSB +: 4] = decim;
      ctrl_word[`FFT_IE_BIT] = ie;
      ctrl_word[`FFT_CF_BIT] = flag;
      ctrl_word[`FFT_BSY_BIT] = (state != fft_pkg::ST_IDLE);
      case (s_adr_i)
         `FFT_CTRL_OFS: rd_word = ctrl_word;
         `FFT_REAL_OFS: rd_word = real_base;
         `FFT_IMAG_OFS: rd_word = imag_base;
         `FFT_WIN_OFS: rd_word = win_base;
         `FFT_OUT_OFS: rd_word = out_base;
         `FFT_LOOP_OFS: rd_word = {loop_idx, loop_len};
         default: rd_word = ram_rd;
      endcase
   end

   // answer one cycle after the request
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s_ack_o <= 1'b0;
         s_err_o <= 1'b0;
         s_dat_o <= `FFT_RST_WORD;
      end
      else
      begin
         s_ack_o <= take & ~(ram_hit & enable);
         s_err_o <= take & ram_hit & enable;
         if (take)
            s_dat_o <= rd_word;
      end
   end

   // control fields and start
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         enable <= 1'b0;
         inverse <= 1'b0;
         win_en <= 1'b0;
         ie <= 1'b0;
         pts_code <= 3'h0;
         decim <= 4'h0;
      end
      else
      begin
         if (ctrl_wr)
            ie <= s_dat_i[`FFT_IE_BIT];
         if (ctrl_wr && !enable)
         begin
            pts_code <= s_dat_i[`FFT_PTS_LSB +: 3];
            inverse <= s_dat_i[`FFT_INV_BIT];
            win_en <= s_dat_i[`FFT_WIN_BIT];
            decim <= s_dat_i[`FFT_DEC_LSB +: 4];
            enable <= s_dat_i[`FFT_EN_BIT];
         end
         if (done)
            enable <= 1'b0;
      end
   end

   // completion flag, set wins over clear
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         flag <= 1'b0;
      else
         flag <= done | (flag & ~(ctrl_wr & s_dat_i[`FFT_CF_BIT]));
   end

   // base addresses and loop length
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         real_base <= `FFT_RST_WORD;
         imag_base <= `FFT_RST_WORD;
         win_base <= `FFT_RST_WORD;
         out_base <= `FFT_RST_WORD;
         loop_len <= 16'h0;
      end
      else if (reg_wr && !enable)
      begin
         case (s_adr_i)
            `FFT_REAL_OFS: real_base <= s_dat_i;
            `FFT_IMAG_OFS: imag_base <= s_dat_i;
            `FFT_WIN_OFS: win_base <= s_dat_i;
            `FFT_OUT_OFS: out_base <= s_dat_i;
            `FFT_LOOP_OFS: loop_len <= s_dat_i[15:0];
            default: ;
         endcase
      end
   end

   // loop index
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         loop_idx <= 16'h0;
      else if (done)
         loop_idx <= (17'(loop_idx) + 17'd1 >= 17'(loop_len)) ? 16'h0 : loop_idx + 16'd1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // butterfly datapath

   logic [AW-1:0] pos; // offset in group
   logic [AW-1:0] a_ix; // upper input
   logic [AW-1:0] b_ix; // lower input
   logic [AW-2:0] w_ix; // twiddle index
   logic [31:0] w_im; // twiddle imag part
   logic [31:0] bw_re; // B*W real
   logic [31:0] bw_im; // B*W imag

   // pass s pairs points 2 to the power s apart
   always_comb
   begin
      pos = AW'(bf) & ((AW'(1) << stage) - AW'(1));
      a_ix = ((AW'(bf) >> stage) << (stage + 4'd1)) | pos;
      b_ix = a_ix | (AW'(1) << stage);
      w_ix = (AW-1)'(pos << (4'(LOG_MAX - 1) - stage));
      w_im = inverse ? tw_s[w_ix] : fneg(tw_s[w_ix]);
      bw_re = fadd(fmul(mem_re[b_ix], tw_c[w_ix]), fneg(fmul(mem_im[b_ix], w_im)));
      bw_im = fadd(fmul(mem_re[b_ix], w_im), fmul(mem_im[b_ix], tw_c[w_ix]));
   end

   // sram writes: load, butterfly, bus
   always_ff @(posedge clk_i)
   begin
      if (state == fft_pkg::ST_LD_PUT)
      begin
         mem_re[bitrev(idx, lg)] <= win_en ? fmul(smp_re, smp_w) : fclean(smp_re);
         mem_im[bitrev(idx, lg)] <= win_en ? fmul(smp_im, smp_w) : fclean(smp_im);
      end
      else if (state == fft_pkg::ST_BFLY)
      begin
         mem_re[a_ix] <= fadd(mem_re[a_ix], bw_re);
         mem_im[a_ix] <= fadd(mem_im[a_ix], bw_im);
         mem_re[b_ix] <= fadd(mem_re[a_ix], fneg(bw_re));
         mem_im[b_ix] <= fadd(mem_im[a_ix], fneg(bw_im));
      end
      else if (ram_wr && ram_w[LOG_MAX])
         mem_im[ram_w[AW-1:0]] <= bmerge(mem_im[ram_w[AW-1:0]], s_dat_i, s_sel_i);
      else if (ram_wr)
         mem_re[ram_w[AW-1:0]] <= bmerge(mem_re[ram_w[AW-1:0]], s_dat_i, s_sel_i);
   end

   ////////////////////////////////////////////////////////////////////////////
   // data master and sequencer

   assign m_stb_o = m_cyc_o;
   assign m_sel_o = 4'hf;
   assign bus_st = state inside {fft_pkg::ST_LD_RE, fft_pkg::ST_LD_IM, fft_pkg::ST_LD_WIN,
      fft_pkg::ST_ST_RE, fft_pkg::ST_ST_IM};
   assign bus_done = m_cyc_o & (m_ack_i | m_err_i);
   // (loop_idx + idx * (decim + 1)) times four from the real and imag bases
   assign fetch_off = (32'(loop_idx) + 32'(idx) * (32'(decim) + 32'd1)) << 2;

   // address and write word per state
   always_comb
   begin
      bus_adr = 32'h0;
      bus_dat = 32'h0;
      case (state)
         fft_pkg::ST_LD_RE: bus_adr = real_base + fetch_off;
         fft_pkg::ST_LD_IM: bus_adr = imag_base + fetch_off;
         fft_pkg::ST_LD_WIN: bus_adr = win_base + (32'(idx) << 2);
         fft_pkg::ST_ST_RE:
         begin
            bus_adr = out_base + (32'(idx) << 3);
            bus_dat = fscale(mem_re[idx], inverse ? lg : 4'h0);
         end
         fft_pkg::ST_ST_IM:
         begin
            bus_adr = out_base + (32'(idx) << 3) + 32'd4;
            bus_dat = fscale(mem_im[idx], inverse ? lg : 4'h0);
         end
         default: ;
      endcase
   end

   // sequencer and master cycles
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state <= fft_pkg::ST_IDLE;
         idx <= '0;
         stage <= 4'h0;
         bf <= '0;
         smp_re <= 32'h0;
         smp_im <= 32'h0;
         smp_w <= 32'h0;
         m_cyc_o <= 1'b0;
         m_we_o <= 1'b0;
         m_adr_o <= 32'h0;
         m_dat_o <= 32'h0;
      end
      else
      begin
         // raise a cycle, drop it on answer
         if (bus_st && !m_cyc_o)
         begin
            m_cyc_o <= 1'b1;
            m_we_o <= (state == fft_pkg::ST_ST_RE) || (state == fft_pkg::ST_ST_IM);
            m_adr_o <= bus_adr;
            m_dat_o <= bus_dat;
         end
         else if (bus_done)
         begin
            m_cyc_o <= 1'b0;
            m_we_o <= 1'b0;
         end
         case (state)
            fft_pkg::ST_IDLE:
               if (enable)
                  state <= fft_pkg::ST_LD_RE;
            fft_pkg::ST_LD_RE:
               if (bus_done)
               begin
                  smp_re <= m_dat_i;
                  state <= fft_pkg::ST_LD_IM;
               end
            fft_pkg::ST_LD_IM:
               if (bus_done)
               begin
                  smp_im <= m_dat_i;
                  state <= win_en ? fft_pkg::ST_LD_WIN : fft_pkg::ST_LD_PUT;
               end
            fft_pkg::ST_LD_WIN:
               if (bus_done)
               begin
                  smp_w <= m_dat_i;
                  state <= fft_pkg::ST_LD_PUT;
               end
            fft_pkg::ST_LD_PUT:
            begin
               idx <= (idx == last) ? '0 : idx + AW'(1);
               state <= (idx == last) ? fft_pkg::ST_BFLY : fft_pkg::ST_LD_RE;
            end
            // N/2 butterflies per pass, lg passes
            fft_pkg::ST_BFLY:
            begin
               bf <= (bf == last[AW-1:1]) ? '0 : bf + (AW-1)'(1);
               if (bf == last[AW-1:1])
               begin
                  stage <= (stage == lg - 4'd1) ? 4'h0 : stage + 4'd1;
                  // copy out after the last pass
                  if (stage == lg - 4'd1)
                     state <= fft_pkg::ST_ST_RE;
               end
            end
            fft_pkg::ST_ST_RE:
               if (bus_done)
                  state <= fft_pkg::ST_ST_IM;
            fft_pkg::ST_ST_IM:
               if (bus_done)
               begin
                  idx <= (idx == last) ? '0 : idx + AW'(1);
                  state <= (idx == last) ? fft_pkg::ST_FINISH : fft_pkg::ST_ST_RE;
               end
            fft_pkg::ST_FINISH: state <= fft_pkg::ST_IDLE;
            default: state <= fft_pkg::ST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // assertions

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   a_ram_busy_err: assert property (take && ram_hit && enable |=> s_err_o && !s_ack_o)
      else $error("sram access while busy not refused");
   a_ram_idle_ack: assert property (take && ram_hit && !enable |=> s_ack_o && !s_err_o)
      else $error("sram access while idle not acked");
   a_enable_drop: assert property (done |=> !enable && flag && state == fft_pkg::ST_IDLE)
      else $error("finish did not clear enable");
   a_loop_wrap: assert property (done && 17'(loop_idx) + 17'd1 >= 17'(loop_len) |=> loop_idx == 16'h0)
      else $error("loop index did not wrap");
   a_loop_step: assert property (done && 17'(loop_idx) + 17'd1 < 17'(loop_len)
      |=> loop_idx == $past(loop_idx) + 16'd1)
      else $error("loop index did not advance");
   a_cfg_frozen: assert property (enable |=> $stable(real_base) && $stable(pts_code) && $stable(inverse))
      else $error("setting changed while busy");
   a_store_only: assert property (m_cyc_o && m_we_o |-> state inside {fft_pkg::ST_ST_RE, fft_pkg::ST_ST_IM})
      else $error("master write outside copy out");
   a_fetch_addr: assert property (state == fft_pkg::ST_LD_RE && !m_cyc_o
      |=> m_cyc_o && !m_we_o && m_adr_o == real_base + fetch_off)
      else $error("wrong real fetch address");
   a_flag_clear: assert property (ctrl_wr && s_dat_i[`FFT_CF_BIT] && !done |=> !flag)
      else $error("completion flag not cleared");
endmodule

//--- tb/fft_memory_model.sv
// memory model on the far side of the data master
module fft_memory_model (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave side
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [31:0] adr_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // extra wait states when high
   input wire logic slow_i
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [31:0] mem [0:1023]; // word store, bench fills it
   logic [1:0] wait_q; // wait countdown
   // one-cycle ack; data only with ack, toggling otherwise
   always @(posedge clk_i)
   begin
      ack_o <= 1'b0;
      dat_o <= ~dat_o;
      if (rst_i)
      begin
         wait_q <= 2'h0;
         dat_o <= 32'h0;
      end
      else if (cyc_i && stb_i && !ack_o)
      begin
         if (wait_q != 2'h0)
            wait_q <= wait_q - 2'h1;
         else
         begin
            ack_o <= 1'b1;
            wait_q <= slow_i ? 2'h3 : 2'h0;
            if (we_i)
               mem[adr_i[11:2]] <= dat_i;
            else
               dat_o <= mem[adr_i[11:2]];
         end
      end
   end
endmodule

//--- tb/fft_accelerator_bench.sv
// self-checking bench for the fft accelerator
module fft_accelerator_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_i, rst_i, cyc, stb, we, ack, err, m_cyc, m_stb, m_we, m_ack, irq, slow, e;
   logic [15:0] adr;
   logic [3:0] sel;
   logic [31:0] wdat, rdat, m_adr, m_wdat, m_rdat, rd;
   int n_errors, comparisons, cycles;
   fft_accelerator #(.LOG_MAX(5)) u_fft_accelerator (.clk_i(clk_i), .rst_i(rst_i), .s_cyc_i(cyc),
      .s_stb_i(stb), .s_we_i(we), .s_adr_i(adr), .s_sel_i(sel), .s_dat_i(wdat), .s_dat_o(rdat),
      .s_ack_o(ack), .s_err_o(err), .m_cyc_o(m_cyc), .m_stb_o(m_stb), .m_we_o(m_we), .m_adr_o(m_adr),
      .m_sel_o(), .m_dat_o(m_wdat), .m_dat_i(m_rdat), .m_ack_i(m_ack), .m_err_i(1'b0), .irq_o(irq));
   fft_memory_model u_fft_memory_model (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(m_cyc), .stb_i(m_stb),
      .we_i(m_we), .adr_i(m_adr), .dat_i(m_wdat), .dat_o(m_rdat), .ack_o(m_ack), .slow_i(slow));
   // 100 ns clock
   initial
   begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   // hang guard
   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 30000)
      begin
         n_errors++;
         report_and_stop();
      end
   end
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task report_and_stop();
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // one classic cycle, waits for ack or err
   // no local limit: only the hang guard ends a wait
   task wb(input logic w, input logic [15:0] a, input logic [31:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do
         @(posedge clk_i);
      while (!(ack || err));
      rd = rdat;
      e = err;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask
   task fill();
      for (int i = 0; i < 64; i++)
      begin
         u_fft_memory_model.mem[i] = 32'h3f80_0000;
         u_fft_memory_model.mem[256 + i] = 32'h0;
      end
      u_fft_memory_model.mem[0] = 32'h4000_0000;
      u_fft_memory_model.mem[261] = 32'h0000_0001;
   endtask
   // start, probe while busy, poll until enable clears
   task run_fft(input logic [31:0] ctrl);
      int n;
      wb(1'b1, 16'h0000, ctrl);
      wb(1'b0, 16'h0800, 32'h0);
      chk({31'h0, e}, 32'h1);
      wb(1'b1, 16'h0010, 32'h0000_0f00);
      wb(1'b0, 16'h0010, 32'h0);
      chk(rd, 32'h0000_0800);
      n = 0;
      do
         wb(1'b0, 16'h0000, 32'h0);
      while (rd[0] !== 1'b0 && n++ < 500);
      // an expired poll counts as a mismatch
      chk({31'h0, rd[0]}, 32'h0);
   endtask
   task t_regs();
      wb(1'b0, 16'h0000, 32'h0);
      chk(rd, 32'h0);
      wb(1'b0, 16'h0100, 32'h0);
      chk(rd, 32'h0);
      wb(1'b1, 16'h0804, 32'ha5a5_5a5a);
      wb(1'b0, 16'h0804, 32'h0);
      chk(rd, 32'ha5a5_5a5a);
      $display("regs test done");
   endtask
   task t_forward();
      fill();
      wb(1'b1, 16'h0008, 32'h0000_0400);
      wb(1'b1, 16'h0010, 32'h0000_0800);
      wb(1'b1, 16'h0014, 32'h0000_0002);
      slow <= 1'b1;
      run_fft(32'h2000_0001);
      chk(rd & 32'h4000_0001, 32'h4000_0000);
      chk({31'h0, irq}, 32'h1);
      chk(u_fft_memory_model.mem[512], 32'h4204_0000);
      chk(u_fft_memory_model.mem[513] & 32'h7fff_ffff, 32'h0);
      chk(u_fft_memory_model.mem[514], 32'h3f80_0000);
      wb(1'b0, 16'h0014, 32'h0);
      chk(rd, 32'h0001_0002);
      wb(1'b1, 16'h0000, 32'h6000_0000);
      chk({31'h0, irq}, 32'h0);
      $display("forward test done");
   endtask
   task t_inverse();
      slow <= 1'b0;
      run_fft(32'h0000_0011);
      chk(u_fft_memory_model.mem[512], 32'h3f80_0000);
      chk(u_fft_memory_model.mem[514] & 32'h7fff_ffff, 32'h0);
      wb(1'b0, 16'h0014, 32'h0);
      chk(rd, 32'h0000_0002);
      $display("inverse test done");
   endtask
   // window of 0.5, stride 2: mem[1] is skipped only when decimating
   task t_window();
      for (int i = 0; i < 32; i++)
         u_fft_memory_model.mem[768 + i] = 32'h3f00_0000;
      u_fft_memory_model.mem[1] = 32'h4000_0000;
      wb(1'b1, 16'h000c, 32'h0000_0c00);
      run_fft(32'h0000_0301);
      chk(u_fft_memory_model.mem[512], 32'h4184_0000);
      chk(u_fft_memory_model.mem[514], 32'h3f00_0000);
      $display("window test done");
   endtask
   initial
   begin
      rst_i = 1'b1;
      {cyc, stb, we, slow} = 4'h0;
      sel = 4'hf;
      adr = 16'h0;
      wdat = 32'h0;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_regs();
      t_forward();
      t_inverse();
      t_window();
      report_and_stop();
   end
endmodule
